// ===== src/adsc_map.svh
// constants for the converter display and status control block
`ifndef ADSC_MAP_SVH
`define ADSC_MAP_SVH

// result magnitude limits: over above 19,999, under below 1000
`define ADSC_OVER_LIMIT   16'h4E1F
`define ADSC_UNDER_LIMIT  16'h03E8

// clock period and low time of the latch update strobe
`define ADSC_CLK_NS       5
`define ADSC_PULSE_NS     100
`define ADSC_PULSE_CYC    ((`ADSC_PULSE_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)

// cycles the strobe pin must be driven high before its level is trusted
`define ADSC_SETTLE_CYC   4

// reset values
`define ADSC_RST_COUNT    16'h0000
`define ADSC_RST_FLAG     1'h0
`define ADSC_RST_PULSE    5'h00

`endif

// ===== src/adsc_pkg.sv
// types for the converter display and status control block
package adsc_pkg;

  // latch/hold pin mode, gray along free -> live -> hold
  typedef enum logic [1:0] {
    ADSC_FREE = 2'h0,
    ADSC_LIVE = 2'h1,
    ADSC_HOLD = 2'h3
  } adsc_mode_t;

  // pin levels and the threshold comparator, all asynchronous
  typedef struct packed {
    logic topPointOverrange;
    logic secondPointUnderrange;
    logic latchHold;
    logic continuity;
    logic rangeSelect;
    logic pointTwoEnable;
    logic pointOneEnable;
    logic belowThreshold;
  } adsc_pins_t;

  // drive of the two-way pins, enables active low
  typedef struct packed {
    logic topOut;
    logic topOeN;
    logic secondOut;
    logic secondOeN;
    logic latchOut;
    logic latchOeN;
    logic contOut;
    logic contOeN;
  } adsc_padout_t;

  // conversion sequencer status, same clock
  typedef struct packed {
    logic [15:0] count;
    logic        negative;
    logic        deintegrate;
    logic        done;
  } adsc_conv_t;

  // what the display shows
  typedef struct packed {
    logic [15:0] count;
    logic        negative;
    logic        pointTop;
    logic        pointSecond;
    logic        pointTwo;
    logic        pointOne;
    logic        continuityFlag;
    logic        overrange;
    logic        underrange;
    logic        scale2V;
  } adsc_disp_t;

endpackage

// ===== src/adsc_ctrl.sv
// display, range and status control of the dual-slope converter
`timescale 1ns/1ps
`include "adsc_map.svh"

module adsc_ctrl (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire adsc_pkg::adsc_pins_t   pinIn,
  input  wire adsc_pkg::adsc_conv_t   conv,
  output adsc_pkg::adsc_padout_t      padOut,
  output adsc_pkg::adsc_disp_t        disp,
  output adsc_pkg::adsc_mode_t        mode
);

  localparam logic [4:0] PULSE_CYC  = 5'(`ADSC_PULSE_CYC);
  localparam logic [2:0] SETTLE_CYC = 3'(`ADSC_SETTLE_CYC);

  adsc_pkg::adsc_pins_t syncA_r;
  adsc_pkg::adsc_pins_t syncB_r;
  adsc_pkg::adsc_mode_t mode_r;
  adsc_pkg::adsc_mode_t mode_nxt;
  logic [4:0]           pulseCnt_r;
  logic [2:0]           highAge_r;
  logic                 pulseActive;
  logic                 pulseEnd;
  logic                 highSettled;
  logic                 loadLatch;
  logic                 liveShow;
  logic [15:0]          count_r;
  logic                 negative_r;
  logic                 overrange_r;
  logic                 underrange_r;
  logic                 pointTop_r;
  logic                 pointSecond_r;
  logic                 pointTwo_r;
  logic                 pointOne_r;
  logic                 contFlag_r;
  logic                 scale2V_r;
  logic                 below_r;

  // two-stage synchroniser; stage A feeds only stage B
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
    end
  end

  assign pulseActive = (pulseCnt_r != `ADSC_RST_PULSE);
  assign pulseEnd    = (pulseCnt_r == 5'h01);
  assign highSettled = !pulseActive && (highAge_r == SETTLE_CYC);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulseCnt_r <= `ADSC_RST_PULSE;
    end else if (conv.done) begin
      pulseCnt_r <= PULSE_CYC;
    end else if (pulseActive) begin
      pulseCnt_r <= pulseCnt_r - 5'h01;
    end
  end

  // time since the strobe pin went back high, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      highAge_r <= 3'h0;
    end else if (pulseActive) begin
      highAge_r <= 3'h0;
    end else if (highAge_r != SETTLE_CYC) begin
      highAge_r <= highAge_r + 3'h1;
    end
  end

  // mode sensing: our drive is weak, so an external level wins.
  // a high seen while we pull low means held high; a low seen
  // while we drive high means held low; otherwise floating.
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      adsc_pkg::ADSC_FREE: begin
        if (pulseEnd && syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_HOLD;
        end else if (highSettled && !syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_LIVE;
        end
      end
      adsc_pkg::ADSC_LIVE: begin
        if (pulseEnd && syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_HOLD;
        end else if (highSettled && syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_FREE;
        end
      end
      adsc_pkg::ADSC_HOLD: begin
        // release to floating is only seen at the next strobe; a held low is seen as soon as highSettled
        if (pulseEnd && !syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_FREE;
        end else if (highSettled && !syncB_r.latchHold) begin
          mode_nxt = adsc_pkg::ADSC_LIVE;
        end
      end
      default: begin
        mode_nxt = adsc_pkg::ADSC_FREE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= adsc_pkg::ADSC_FREE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign loadLatch = conv.done && (mode_r != adsc_pkg::ADSC_HOLD);
  assign liveShow  = (mode_r == adsc_pkg::ADSC_LIVE) && conv.deintegrate;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r    <= `ADSC_RST_COUNT;
      negative_r <= `ADSC_RST_FLAG;
    end else if (loadLatch || liveShow) begin
      count_r    <= conv.count;
      negative_r <= conv.negative;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrange_r  <= `ADSC_RST_FLAG;
      underrange_r <= `ADSC_RST_FLAG;
    end else if (loadLatch) begin
      overrange_r  <= (conv.count > `ADSC_OVER_LIMIT);
      underrange_r <= (conv.count < `ADSC_UNDER_LIMIT);
    end
  end

  // annunciators follow the synchronised pin levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pointTop_r    <= `ADSC_RST_FLAG;
      pointSecond_r <= `ADSC_RST_FLAG;
      pointTwo_r    <= `ADSC_RST_FLAG;
      pointOne_r    <= `ADSC_RST_FLAG;
      contFlag_r    <= `ADSC_RST_FLAG;
    end else begin
      pointTop_r    <= syncB_r.topPointOverrange;
      pointSecond_r <= syncB_r.secondPointUnderrange;
      pointTwo_r    <= syncB_r.pointTwoEnable;
      pointOne_r    <= syncB_r.pointOneEnable;
      contFlag_r    <= syncB_r.continuity;
    end
  end

  // range and threshold comparator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scale2V_r <= `ADSC_RST_FLAG;
      below_r   <= `ADSC_RST_FLAG;
    end else begin
      scale2V_r <= syncB_r.rangeSelect;
      below_r   <= syncB_r.belowThreshold;
    end
  end

  // top, second and continuity pins pull high only; they read low through a pull-down,
  // so an external driver never fights a low from us there; the latch pin is driven low during the strobe
  always_comb begin
    padOut.topOut    = 1'h1;
    padOut.topOeN    = !overrange_r;
    padOut.secondOut = 1'h1;
    padOut.secondOeN = !underrange_r;
    padOut.latchOut  = !pulseActive;
    padOut.latchOeN  = 1'h0;
    padOut.contOut   = 1'h1;
    padOut.contOeN   = !below_r;
  end

  always_comb begin
    disp.count          = count_r;
    disp.negative       = negative_r;
    disp.pointTop       = pointTop_r;
    disp.pointSecond    = pointSecond_r;
    disp.pointTwo       = pointTwo_r;
    disp.pointOne       = pointOne_r;
    disp.continuityFlag = contFlag_r;
    disp.overrange      = overrange_r;
    disp.underrange     = underrange_r;
    disp.scale2V        = scale2V_r;
  end

  assign mode = mode_r;

endmodule

// ===== bench/adsc_ctrl_sva.sv
// assertion checker for the display and status control block
`timescale 1ns/1ps
module adsc_ctrl_sva (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire adsc_pkg::adsc_pins_t   pinIn,
  input wire adsc_pkg::adsc_conv_t   conv,
  input wire adsc_pkg::adsc_padout_t padOut,
  input wire adsc_pkg::adsc_disp_t   disp,
  input wire adsc_pkg::adsc_mode_t   mode
);
  logic [4:0] lowCnt_r;
  logic       load;
  assign load = conv.done && mode != adsc_pkg::ADSC_HOLD;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // saturates: a restarted strobe stays low longer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      lowCnt_r <= 5'h00;
    else if (padOut.latchOut)
      lowCnt_r <= 5'h00;
    else if (lowCnt_r != 5'h1F)
      lowCnt_r <= lowCnt_r + 5'h01;
  end
  property p_over;
    load |=> disp.overrange == ($past(conv.count) > 16'h4E1F);
  endproperty
  a_over: assert property (p_over) else $error("overrange wrong");
  property p_under;
    load |=> disp.underrange == ($past(conv.count) < 16'h03E8);
  endproperty
  a_under: assert property (p_under) else $error("underrange wrong");
  property p_flagPins;
    padOut.topOeN != disp.overrange && padOut.secondOeN != disp.underrange;
  endproperty
  a_flagPins: assert property (p_flagPins) else $error("flag pin");
  property p_hold;
    mode == adsc_pkg::ADSC_HOLD |=> $stable(disp.count);
  endproperty
  a_hold: assert property (p_hold) else $error("hold moved count");
  property p_fall;
    conv.done |=> !padOut.latchOut;
  endproperty
  a_fall: assert property (p_fall) else $error("no strobe edge");
  property p_len;
    $rose(padOut.latchOut) |-> lowCnt_r >= 5'h14;
  endproperty
  a_len: assert property (p_len) else $error("strobe too short");
  property p_live;
    mode == adsc_pkg::ADSC_LIVE && conv.deintegrate
      |=> disp.count == $past(conv.count);
  endproperty
  a_live: assert property (p_live) else $error("live count wrong");
  property p_pointOne;
    $stable(pinIn.pointOneEnable) [*4] |-> disp.pointOne == pinIn.pointOneEnable;
  endproperty
  a_pointOne: assert property (p_pointOne) else $error("point one");
  property p_cont;
    $stable(pinIn.belowThreshold) [*4] |-> padOut.contOeN != pinIn.belowThreshold;
  endproperty
  a_cont: assert property (p_cont) else $error("continuity drive");
  c_over: cover property (load && conv.count > 16'h4E1F);
  c_hold: cover property (conv.done && mode == adsc_pkg::ADSC_HOLD);
  c_live: cover property (mode == adsc_pkg::ADSC_LIVE && conv.deintegrate);
endmodule
bind adsc_ctrl adsc_ctrl_sva adsc_ctrl_sva_i (.clk(clk), .resetn(resetn),
  .pinIn(pinIn), .conv(conv), .padOut(padOut), .disp(disp), .mode(mode));

// ===== bench/adsc_panel.sv
// front-panel switches and pull-downs resolving the shared pins
`timescale 1ns/1ps
module adsc_panel (
  input wire adsc_pkg::adsc_padout_t padOut,
  input wire adsc_pkg::adsc_pins_t   ext,
  input wire logic [1:0]             latchDrv,
  output adsc_pkg::adsc_pins_t       pins
);
  always_comb begin
    pins = ext;
    pins.topPointOverrange = ext.topPointOverrange | !padOut.topOeN;
    pins.secondPointUnderrange = ext.secondPointUnderrange | !padOut.secondOeN;
    pins.continuity = ext.continuity | !padOut.contOeN;
    // external driver beats the weak self-drive
    pins.latchHold = latchDrv[1] ? latchDrv[0] : padOut.latchOut;
  end
endmodule

// ===== bench/adsc_ctrl_test.sv
// self-checking testbench for the display and status control block
`timescale 1ns/1ps
module adsc_ctrl_test;
  logic                  clk;
  logic                  resetn;
  logic [1:0]            latchDrv;
  adsc_pkg::adsc_pins_t  ext;
  adsc_pkg::adsc_pins_t  pins;
  adsc_pkg::adsc_conv_t  conv;
  adsc_pkg::adsc_padout_t padOut;
  adsc_pkg::adsc_disp_t  disp;
  adsc_pkg::adsc_mode_t  mode;
  int                    fails;
  int                    samples_checked;
  // last value sets neither flag, so the shared pins read low afterwards
  logic [15:0]           vals [6] = '{16'h4E1F, 16'h4E20, 16'h03E7,
                                      16'h0000, 16'hFFFF, 16'h03E8};
  adsc_ctrl adsc_ctrl_i (.clk(clk), .resetn(resetn), .pinIn(pins),
    .conv(conv), .padOut(padOut), .disp(disp), .mode(mode));
  adsc_panel adsc_panel_i (.padOut(padOut), .ext(ext),
    .latchDrv(latchDrv), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task load(input logic [15:0] c);
    @(negedge clk);
    conv.count = c;
    conv.done = 1'b1;
    @(negedge clk);
    conv.done = 1'b0;
  endtask
  task final_report;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    latchDrv = 2'h0;
    ext = '0;
    conv = '0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    foreach (vals[i]) begin
      load(vals[i]);
      chk(disp.count, vals[i]);
      chk(pins.topPointOverrange, vals[i] > 16'h4E1F);
      chk(pins.secondPointUnderrange, vals[i] < 16'h03E8);
      chk(pins.latchHold, 1'b0);
      repeat (22) @(negedge clk);
    end
    for (int p = 0; p < 2; p++) begin
      // range select stays low here
      ext = p ? 8'hD7 : 8'h00;
      repeat (4) @(negedge clk);
      chk(disp.pointTop, p);
      chk(disp.pointSecond, p);
      chk(disp.continuityFlag, p);
      chk(disp.pointTwo, p);
      chk(disp.pointOne, p);
      chk(disp.scale2V, 1'b0);
      chk(padOut.contOeN, !p);
    end
    ext = 8'h08;
    repeat (4) @(negedge clk);
    chk(disp.scale2V, 1'b1);
    latchDrv = 2'h3;
    repeat (4) @(negedge clk);
    load(16'h0064);
    repeat (22) @(negedge clk);
    chk(mode, adsc_pkg::ADSC_HOLD);
    load(16'h0005);
    chk(disp.count, 16'h0064);
    repeat (22) @(negedge clk);
    latchDrv = 2'h2;
    repeat (10) @(negedge clk);
    chk(mode, adsc_pkg::ADSC_LIVE);
    conv.deintegrate = 1'b1;
    for (int k = 1; k < 4; k++) begin
      conv.count = 16'(k * 300);
      @(negedge clk);
      chk(disp.count, 16'(k * 300));
    end
    conv.deintegrate = 1'b0;
    latchDrv = 2'h0;
    repeat (10) @(negedge clk);
    chk(mode, adsc_pkg::ADSC_FREE);
    conv.negative = 1'b1;
    load(16'h0309);
    chk(disp.count, 16'h0309);
    chk(disp.negative, 1'b1);
    final_report;
  end
endmodule
